/* smo_pkg.sv */
// Purpose: Shared constants and carriers for the stack-multiple and MAC execution unit
// Assumes: Word-wide stack memory with a 20-bit byte address
// Notes:   Single-byte opcodes are zero-extended to 16 bits
package smo_pkg;

    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [15:0] OP_PUSH_MASKED    = 16'h0034;
    localparam logic [15:0] OP_PULL_MASKED    = 16'h0035;
    localparam logic [15:0] OP_PUSH_MAC_STATE = 16'h27B8;
    localparam logic [15:0] OP_PULL_MAC_STATE = 16'h27B9;
    localparam logic [15:0] OP_PULL_ACC_A     = 16'h3709;
    localparam logic [15:0] OP_PULL_ACC_B     = 16'h3719;
    localparam logic [15:0] OP_REPEAT_MAC     = 16'h00FB;

    // ************************************************************
    // Cycle budget: lead cycles, then two cycles per stack word or twelve per repeat-MAC step
    // ************************************************************
    localparam logic [3:0] LEAD_PUSH      = 4'h4;
    localparam logic [3:0] LEAD_PULL      = 4'h6;
    localparam logic [3:0] LEAD_BYTE      = 4'h4;
    localparam logic [3:0] LEAD_REPEAT_MAC      = 4'h6;
    localparam logic [3:0] REPEAT_MAC_STEP_LAST = 4'hB;
    localparam logic [7:0] MAC_STATE_MASK = 8'h1F;

    // Stack pointer steps
    localparam logic [19:0] STACK_WORD = 20'h00002;
    localparam logic [19:0] STACK_BYTE = 20'h00001;

    // ************************************************************
    // Register port word offsets
    // ************************************************************
    localparam logic [4:0] ADR_ACC_D   = 5'h00;
    localparam logic [4:0] ADR_ACC_E   = 5'h01;
    localparam logic [4:0] ADR_INDEX_X = 5'h02;
    localparam logic [4:0] ADR_INDEX_Y = 5'h03;
    localparam logic [4:0] ADR_INDEX_Z = 5'h04;
    localparam logic [4:0] ADR_EXT_K   = 5'h05;
    localparam logic [4:0] ADR_FLAGS   = 5'h06;
    localparam logic [4:0] ADR_STK_EXT = 5'h07;
    localparam logic [4:0] ADR_STK_PTR = 5'h08;
    localparam logic [4:0] ADR_MUL_H   = 5'h09;
    localparam logic [4:0] ADR_MUL_I   = 5'h0A;
    localparam logic [4:0] ADR_SUM_LO  = 5'h0B;
    localparam logic [4:0] ADR_SUM_HI  = 5'h0C;
    localparam logic [4:0] ADR_SUM_EXT = 5'h0D;
    localparam logic [4:0] ADR_STATUS  = 5'h0E;

    // Flag word bit positions
    localparam int FLAG_MV       = 14;
    localparam int FLAG_EV       = 12;
    localparam int FLAG_PULL_LSB = 4;

    // Register selectors for stack transfers
    typedef enum logic [3:0] {
        SEL_D    = 4'h0, SEL_E    = 4'h1, SEL_X    = 4'h2, SEL_Y   = 4'h3,
        SEL_Z    = 4'h4, SEL_K    = 4'h5, SEL_CCR  = 4'h6, SEL_H   = 4'h7,
        SEL_I    = 4'h8, SEL_AMX  = 4'h9, SEL_AMH  = 4'hA, SEL_AML = 4'hB,
        SEL_A    = 4'hC, SEL_B    = 4'hD, SEL_NONE = 4'hF
    } smo_sel_e;

    typedef enum logic [5:0] {
        MD_PUSHM   = 6'b000001,
        MD_PULLM   = 6'b000010,
        MD_PUSHMAC = 6'b000100,
        MD_PULLMAC = 6'b001000,
        MD_PULLB   = 6'b010000,
        MD_REPEAT_MAC    = 6'b100000
    } smo_mode_e;

    typedef struct packed {
        logic [15:0] opcode;
        logic [7:0]  operand;
    } smo_instr_s;

    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] wdata;
        logic        we;
        logic        re;
        logic        byte_rd;
    } smo_mem_req_s;

endpackage

/* smo_mac_step.sv */
// Purpose: One signed fractional multiply-accumulate step
// Assumes: Operands are signed 16-bit fractions, sum is 36 bits
// Notes:   Purely combinational
`timescale 1ns/1ps
module smo_mac_step
    import smo_pkg::*;
(
    input  wire logic [35:0] sum_in,   // Current accumulated sum
    input  wire logic [15:0] mul_h,    // First operand
    input  wire logic [15:0] mul_i,    // Second operand
    output logic      [35:0] sum_out,  // New sum
    output logic             sum_ovf,  // Sum left the 36-bit range
    output logic             ext_used  // Sum needs extension bits
);
    logic signed [31:0] prod;
    logic        [35:0] frac;

    always_comb begin
        prod    = $signed(mul_h) * $signed(mul_i);
        // Fraction alignment: shift left once, extend from the true sign so -1 * -1 stays positive
        frac    = {{3{prod[31]}}, prod, 1'b0};
        sum_out = sum_in + frac;
        sum_ovf = (sum_in[35] == frac[35]) && (sum_out[35] != sum_in[35]);
        ext_used = !((&sum_out[35:31]) || !(|sum_out[35:31]));
    end
endmodule

/* smo_exec.sv */
// Purpose: Executes masked push/pull, byte pulls, MAC state save/restore and repeat MAC
// Assumes: Stack memory answers a read in the same cycle as its strobe
// Notes:   Register port writes are ignored while an instruction runs
//
// Functional notes
// - Push mask: D,E,X,Y,Z,K,flags; 4+2N cycles
// - Each pushed word lowers stack by two
// - Save MAC state in 14 cycles
// - Byte pulls add two first; 6 cycles
// - Byte pulls subtract one after load
// - Masked pull adds two then loads
// - Pull order flags-high,K,Z,Y,X,E,D
// - Restore MAC state in 16 cycles
// - Repeat MAC, decrement E until negative
// - Step accumulates, steps indexes, reloads operands
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module smo_exec
    import smo_pkg::*;
(
    input  wire logic         clock,     // 200 MHz system clock
    input  wire logic         rst,       // Asynchronous reset, active high
    input  wire logic         start,     // Issue strobe for instr
    input  wire smo_instr_s   instr,     // Opcode and operand byte
    output logic              busy,      // Instruction in progress
    output logic              done,      // Pulse on the last busy cycle
    output logic              bad_op,    // Pulse: opcode not handled here
    output smo_mem_req_s      mem_req,   // Stack memory request
    input  wire logic [15:0]  mem_rdata, // Read data, same cycle as re
    input  wire logic [4:0]   reg_addr,  // Register port word address
    input  wire logic [15:0]  reg_wdata, // Register port write data
    input  wire logic         reg_wr,    // Register write strobe
    input  wire logic         reg_rd,    // Register read strobe
    output logic      [15:0]  reg_rdata  // Read data, one cycle later
);
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_LEAD  = 5'b00010,
        ST_ISSUE = 5'b00100,
        ST_CAPT  = 5'b01000,
        ST_MAC   = 5'b10000
    } smo_state_e;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic [2:0] low_bit(input logic [7:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int b = 6; b >= 0; b--) begin
            if (m[b]) begin
                r = 3'(b);
            end
        end
        return r;
    endfunction

    function automatic smo_sel_e sel_of(input smo_mode_e md, input logic [2:0] b);
        smo_sel_e s;
        s = SEL_NONE;
        case (md)
            MD_PUSHM: begin
                s = smo_sel_e'({1'b0, b});
            end
            MD_PULLM: begin
                s = smo_sel_e'({1'b0, 3'h6 - b});
            end
            MD_PUSHMAC: begin
                s = smo_sel_e'(4'(SEL_H) + {1'b0, b});
            end
            MD_PULLMAC: begin
                s = smo_sel_e'(4'(SEL_AML) - {1'b0, b});
            end
            MD_PULLB: begin
                s = (b == 3'h0) ? SEL_A : SEL_B;
            end
            default: begin
                s = SEL_NONE;
            end
        endcase
        return s;
    endfunction

    function automatic logic [15:0] qualify(input logic [15:0] p, input logic [3:0] off,
                                            input logic [3:0] msk);
        logic [15:0] nxt;
        nxt = p + {{12{off[3]}}, off};
        if (msk != 4'h0) begin
            nxt = (p & ~{12'h000, msk}) | (nxt & {12'h000, msk});
        end
        return nxt;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    smo_state_e  state_r;
    smo_mode_e   mode_r;
    logic [7:0]  mask_r;
    logic [3:0]  cnt_r;
    logic [7:0]  offs_r;
    logic        done_r;
    logic        bad_r;

    logic [15:0] d_r, e_r, x_r, y_r, z_r, k_r, ccr_r, h_r, i_r;
    logic [19:0] sksp_r;
    logic [35:0] am_r;
    logic [3:0]  xmsk_r, ymsk_r;

    logic        is_push;
    logic        last_item;
    smo_sel_e    cur_sel;
    logic [15:0] push_val;
    logic [19:0] sksp_nxt;
    logic [35:0] am_nxt;
    logic        mv_nxt, ev_nxt;

    assign is_push   = (mode_r == MD_PUSHM) || (mode_r == MD_PUSHMAC);
    assign cur_sel   = sel_of(mode_r, low_bit(mask_r));
    assign last_item = (mask_r & (mask_r - 8'h01)) == 8'h00;
    assign busy      = (state_r != ST_IDLE);
    assign done      = done_r;
    assign bad_op    = bad_r;

    smo_mac_step u_mac (
        .sum_in   (am_r),
        .mul_h    (h_r),
        .mul_i    (i_r),
        .sum_out  (am_nxt),
        .sum_ovf  (mv_nxt),
        .ext_used (ev_nxt)
    );

    always_comb begin
        case (cur_sel)
            SEL_D:   push_val = d_r;
            SEL_E:   push_val = e_r;
            SEL_X:   push_val = x_r;
            SEL_Y:   push_val = y_r;
            SEL_Z:   push_val = z_r;
            SEL_K:   push_val = k_r;
            SEL_CCR: push_val = ccr_r;
            SEL_H:   push_val = h_r;
            SEL_I:   push_val = i_r;
            SEL_AMX: push_val = {4'h0, am_r[35:32], xmsk_r, ymsk_r};
            SEL_AMH: push_val = am_r[31:16];
            SEL_AML: push_val = am_r[15:0];
            default: push_val = 16'h0000;
        endcase
    end

    // carry and borrow run into the extension
    always_comb begin
        sksp_nxt = sksp_r;
        if (state_r == ST_ISSUE) begin
            // lower by two per pushed word
            // raise by two before each pull
            // byte pull raises by two first
            sksp_nxt = is_push ? sksp_r - STACK_WORD : sksp_r + STACK_WORD;
        end else if (state_r == ST_CAPT && mode_r == MD_PULLB) begin
            sksp_nxt = sksp_r - STACK_BYTE;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            mode_r  <= MD_PUSHM;
            mask_r  <= 8'h00;
            cnt_r   <= 4'h0;
            offs_r  <= 8'h00;
            done_r  <= 1'b0;
            bad_r   <= 1'b0;
        end else begin
            done_r <= 1'b0;
            bad_r  <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r <= ST_LEAD;
                        offs_r  <= instr.operand;
                        // Mask bit 7 is reserved and never transfers
                        mask_r  <= {1'b0, instr.operand[6:0]};
                        case (instr.opcode)
                            OP_PUSH_MASKED: begin
                                mode_r <= MD_PUSHM;
                                cnt_r  <= LEAD_PUSH - 4'h1;
                            end
                            // pull lead includes the extra pair
                            OP_PULL_MASKED: begin
                                mode_r <= MD_PULLM;
                                cnt_r  <= LEAD_PULL - 4'h1;
                            end
                            OP_PUSH_MAC_STATE: begin
                                mode_r <= MD_PUSHMAC;
                                mask_r <= MAC_STATE_MASK;
                                cnt_r  <= LEAD_PUSH - 4'h1;
                            end
                            // five words after a longer lead
                            OP_PULL_MAC_STATE: begin
                                mode_r <= MD_PULLMAC;
                                mask_r <= MAC_STATE_MASK;
                                cnt_r  <= LEAD_PULL - 4'h1;
                            end
                            OP_PULL_ACC_A, OP_PULL_ACC_B: begin
                                mode_r <= MD_PULLB;
                                mask_r <= (instr.opcode == OP_PULL_ACC_A) ? 8'h01 : 8'h02;
                                cnt_r  <= LEAD_BYTE - 4'h1;
                            end
                            OP_REPEAT_MAC: begin
                                mode_r <= MD_REPEAT_MAC;
                                cnt_r  <= LEAD_REPEAT_MAC - 4'h1;
                            end
                            default: begin
                                state_r <= ST_IDLE;
                                bad_r   <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_LEAD: begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h0) begin
                        // Step counter must open the first iteration at zero
                        cnt_r <= 4'h0;
                        if (mode_r == MD_REPEAT_MAC) begin
                            state_r <= ST_MAC;
                        end else if (mask_r == 8'h00) begin
                            state_r <= ST_IDLE;
                        end else begin
                            state_r <= ST_ISSUE;
                        end
                        if (mode_r != MD_REPEAT_MAC && mask_r == 8'h00) begin
                            done_r <= 1'b0;
                        end
                    end
                    if (cnt_r == 4'h1 && mode_r != MD_REPEAT_MAC && mask_r == 8'h00) begin
                        done_r <= 1'b1;
                    end
                end
                ST_ISSUE: begin
                    state_r <= ST_CAPT;
                    done_r  <= last_item;
                end
                ST_CAPT: begin
                    mask_r <= mask_r & (mask_r - 8'h01);
                    state_r <= last_item ? ST_IDLE : ST_ISSUE;
                end
                ST_MAC: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == REPEAT_MAC_STEP_LAST - 4'h1) begin
                        done_r <= e_r[15];
                    end
                    if (cnt_r == REPEAT_MAC_STEP_LAST) begin
                        cnt_r   <= 4'h0;
                        state_r <= e_r[15] ? ST_IDLE : ST_MAC;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Architectural registers
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {d_r, e_r, x_r, y_r, z_r} <= '0;
            {k_r, ccr_r, h_r, i_r}    <= '0;
            sksp_r <= 20'h00000;
            am_r   <= 36'h000000000;
            xmsk_r <= 4'h0;
            ymsk_r <= 4'h0;
        end else begin
            sksp_r <= sksp_nxt;
            if (state_r == ST_IDLE && reg_wr && !start) begin
                if (reg_addr == ADR_ACC_D) d_r <= reg_wdata;
                else if (reg_addr == ADR_ACC_E) e_r <= reg_wdata;
                else if (reg_addr == ADR_INDEX_X) x_r <= reg_wdata;
                else if (reg_addr == ADR_INDEX_Y) y_r <= reg_wdata;
                else if (reg_addr == ADR_INDEX_Z) z_r <= reg_wdata;
                else if (reg_addr == ADR_EXT_K) k_r <= reg_wdata;
                else if (reg_addr == ADR_FLAGS) ccr_r <= reg_wdata;
                else if (reg_addr == ADR_STK_EXT) sksp_r[19:16] <= reg_wdata[3:0];
                else if (reg_addr == ADR_STK_PTR) sksp_r[15:0] <= reg_wdata;
                else if (reg_addr == ADR_MUL_H) h_r <= reg_wdata;
                else if (reg_addr == ADR_MUL_I) i_r <= reg_wdata;
                else if (reg_addr == ADR_SUM_LO) am_r[15:0] <= reg_wdata;
                else if (reg_addr == ADR_SUM_HI) am_r[31:16] <= reg_wdata;
                else if (reg_addr == ADR_SUM_EXT) {am_r[35:32], xmsk_r, ymsk_r} <= reg_wdata[11:0];
            end
            if (state_r == ST_CAPT && !is_push) begin
                case (cur_sel)
                    SEL_D:   d_r <= mem_rdata;
                    SEL_E:   e_r <= mem_rdata;
                    SEL_X:   x_r <= mem_rdata;
                    SEL_Y:   y_r <= mem_rdata;
                    SEL_Z:   z_r <= mem_rdata;
                    SEL_K:   k_r <= mem_rdata;
                    // only the upper flag bits load
                    SEL_CCR: ccr_r[15:FLAG_PULL_LSB] <= mem_rdata[15:FLAG_PULL_LSB];
                    SEL_H:   h_r <= mem_rdata;
                    SEL_I:   i_r <= mem_rdata;
                    SEL_AMX: {am_r[35:32], xmsk_r, ymsk_r} <= mem_rdata[11:0];
                    SEL_AMH: am_r[31:16] <= mem_rdata;
                    SEL_AML: am_r[15:0] <= mem_rdata;
                    SEL_A:   d_r[15:8] <= mem_rdata[7:0];
                    SEL_B:   d_r[7:0] <= mem_rdata[7:0];
                    default: d_r <= d_r;
                endcase
            end
            if (state_r == ST_MAC) begin
                case (cnt_r)
                    // accumulate, only MV and EV change
                    4'h0: begin
                        am_r <= am_nxt;
                        ccr_r[FLAG_MV] <= mv_nxt;
                        ccr_r[FLAG_EV] <= ev_nxt;
                    end
                    4'h1: begin
                        x_r <= qualify(x_r, offs_r[7:4], xmsk_r);
                        y_r <= qualify(y_r, offs_r[3:0], ymsk_r);
                    end
                    4'h3: h_r <= mem_rdata;
                    4'h5: i_r <= mem_rdata;
                    4'h6: e_r <= e_r - 16'h0001;
                    default: e_r <= e_r;
                endcase
            end
        end
    end

    // ************************************************************
    // Stack memory request
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mem_req <= '0;
        end else begin
            mem_req.we      <= 1'b0;
            mem_req.re      <= 1'b0;
            mem_req.byte_rd <= 1'b0;
            if (state_r == ST_ISSUE) begin
                mem_req.addr    <= is_push ? sksp_r : sksp_nxt;
                mem_req.wdata   <= push_val;
                mem_req.we      <= is_push;
                mem_req.re      <= !is_push;
                mem_req.byte_rd <= (mode_r == MD_PULLB);
            end else if (state_r == ST_MAC && (cnt_r == 4'h2 || cnt_r == 4'h4)) begin
                mem_req.addr <= (cnt_r == 4'h2) ? {k_r[15:12], x_r} : {k_r[11:8], y_r};
                mem_req.re   <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == ADR_ACC_D) reg_rdata <= d_r;
            else if (reg_addr == ADR_ACC_E) reg_rdata <= e_r;
            else if (reg_addr == ADR_INDEX_X) reg_rdata <= x_r;
            else if (reg_addr == ADR_INDEX_Y) reg_rdata <= y_r;
            else if (reg_addr == ADR_INDEX_Z) reg_rdata <= z_r;
            else if (reg_addr == ADR_EXT_K) reg_rdata <= k_r;
            else if (reg_addr == ADR_FLAGS) reg_rdata <= ccr_r;
            else if (reg_addr == ADR_STK_EXT) reg_rdata <= {12'h000, sksp_r[19:16]};
            else if (reg_addr == ADR_STK_PTR) reg_rdata <= sksp_r[15:0];
            else if (reg_addr == ADR_MUL_H) reg_rdata <= h_r;
            else if (reg_addr == ADR_MUL_I) reg_rdata <= i_r;
            else if (reg_addr == ADR_SUM_LO) reg_rdata <= am_r[15:0];
            else if (reg_addr == ADR_SUM_HI) reg_rdata <= am_r[31:16];
            else if (reg_addr == ADR_SUM_EXT) reg_rdata <= {4'h0, am_r[35:32], xmsk_r, ymsk_r};
            else if (reg_addr == ADR_STATUS) reg_rdata <= {11'h000, state_r};
            else reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

/* smo_exec_sva.sv */
// Purpose: Port timing checks on the execution unit
// Assumes: Cycle totals and stack steps as handed over
// Notes:   Attached by bind below the module
`timescale 1ns/1ps
module smo_exec_sva
    import smo_pkg::*;
(
    input wire logic         clock,   // Clock
    input wire logic         rst,     // Reset
    input wire logic         start,   // Issue strobe
    input wire smo_instr_s   instr,   // Instruction
    input wire logic         busy,    // Running
    input wire logic         done,    // Last cycle
    input wire smo_mem_req_s mem_req  // Stack access
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence take(logic [15:0] o); start && !busy && instr.opcode == o; endsequence
    sequence word_pair; mem_req.we ##2 mem_req.we; endsequence
    chk_push_empty_len: assert property (take(OP_PUSH_MASKED) ##0 instr.operand[6:0] == 7'h00 |-> ##4 done)
        else $error("push length");
    chk_push_word_step: assert property (word_pair |-> mem_req.addr == $past(mem_req.addr, 2) - STACK_WORD)
        else $error("push step");
    chk_mac_save_len: assert property (take(OP_PUSH_MAC_STATE) |-> ##14 done) else $error("save length");
    chk_byte_pull_len: assert property ((take(OP_PULL_ACC_A) or take(OP_PULL_ACC_B)) |-> ##6 done)
        else $error("byte pull length");
    chk_mac_load_len: assert property (take(OP_PULL_MAC_STATE) |-> ##16 done) else $error("restore length");
    chk_pull_empty_len: assert property (take(OP_PULL_MASKED) ##0 instr.operand[6:0] == 7'h00 |-> ##6 done)
        else $error("pull length");
    chk_repeat_mac_min_len: assert property (take(OP_REPEAT_MAC) |-> ##18 busy) else $error("repeat short");
    chk_done_ends_busy: assert property (done |=> !busy) else $error("busy after done");
    chk_access_in_busy: assert property (mem_req.we || mem_req.re |-> busy) else $error("idle access");
endmodule
bind smo_exec smo_exec_sva u_sva (.clock, .rst, .start, .instr, .busy, .done, .mem_req);

/* smo_mem_model.sv */
// Purpose: Word-wide stack memory on the far side of the unit
// Assumes: Read data answers in the strobe cycle
// Notes:   Aliases every 512 bytes; idle data lines show the inverse of the last read
`timescale 1ns/1ps
module smo_mem_model
    import smo_pkg::*;
(
    input  wire logic         clock,    // Clock
    input  wire smo_mem_req_s mem_req,  // Request
    output logic      [15:0]  mem_rdata // Read data
);
    logic [15:0] mem [256];
    logic [15:0] w, last_r = 16'h0000;
    assign w = mem[mem_req.addr[8:1]];
    assign mem_rdata = !mem_req.re ? ~last_r :
        mem_req.byte_rd ? {8'h00, mem_req.addr[0] ? w[7:0] : w[15:8]} : w;
    always @(posedge clock) begin
        if (mem_req.re) last_r <= mem_rdata;
        if (mem_req.we) mem[mem_req.addr[8:1]] <= mem_req.wdata;
    end
endmodule

/* stack_multiple_and_mac_ops_tb.sv */
// Purpose: Directed bench for the stack-multiple and MAC execution unit
// Assumes: Register offsets and cycle totals as handed over
// Notes:   Stack words are kept apart because the memory model aliases
`timescale 1ns/1ps
module stack_multiple_and_mac_ops_tb
    import smo_pkg::*;
();
    logic         clock = 1'b0, rst = 1'b1, start = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, busy, done, bad_op;
    logic [15:0]  mem_rdata, reg_rdata, reg_wdata = 16'h0000;
    logic [4:0]   reg_addr = 5'h00;
    smo_instr_s   instr = '0;
    smo_mem_req_s mem_req;
    int           n_fail = 0, checks = 0, n;
    always #2.5 clock = ~clock;
    smo_exec u_dut (.clock, .rst, .start, .instr, .busy, .done, .bad_op, .mem_req, .mem_rdata,
                    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    smo_mem_model u_mem (.clock, .mem_req, .mem_rdata);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        n_fail += int'(seen !== exp);
        if (seen !== exp) $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    endtask
    task automatic results();
        if (n_fail == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge clock) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clock) {reg_wr, reg_rd} <= 2'b00;
        #1 if (!w) chk(reg_rdata, d);
    endtask
    // Busy length is the index of the done cycle after the taking edge
    task automatic run(input logic [15:0] op, input logic [7:0] opd, input logic [15:0] exp);
        @(posedge clock) {start, instr} <= {1'b1, op, opd};
        @(posedge clock) start <= 1'b0;
        #1;
        for (n = 1; n < 300 && done !== 1'b1; n++) @(posedge clock) #1;
        chk(16'(n), exp);
    endtask
    initial begin
        repeat (5000) @(posedge clock);
        chk(16'h0000, 16'hFFFF);
        results();
    end
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        acc(1'b0, 5'h1F, 16'h0000);
        acc(1'b1, ADR_ACC_D, 16'h1234);
        run(OP_PUSH_MASKED, 8'h80, 16'h0004);
        run(OP_PULL_MASKED, 8'h80, 16'h0006);
        run(OP_PUSH_MASKED, 8'h03, 16'h0008);
        acc(1'b0, ADR_STK_EXT, 16'h000F);
        acc(1'b1, ADR_ACC_D, 16'h0000);
        run(OP_PULL_MASKED, 8'h60, 16'h000A);
        acc(1'b0, ADR_ACC_D, 16'h1234);
        u_mem.mem[1] = 16'hABCD;
        run(OP_PULL_ACC_A, 8'h00, 16'h0006);
        run(OP_PULL_ACC_B, 8'h00, 16'h0006);
        acc(1'b0, ADR_ACC_D, 16'hABCD);
        acc(1'b0, ADR_STK_PTR, 16'h0002);
        acc(1'b1, ADR_MUL_H, 16'h4000);
        run(OP_PUSH_MAC_STATE, 8'h00, 16'h000E);
        acc(1'b1, ADR_MUL_H, 16'h0000);
        run(OP_PULL_MAC_STATE, 8'h00, 16'h0010);
        acc(1'b1, ADR_FLAGS, 16'h5AFF);
        acc(1'b1, ADR_MUL_I, 16'h4000);
        run(OP_REPEAT_MAC, 8'h00, 16'h0012);
        acc(1'b0, ADR_SUM_HI, 16'h2000);
        acc(1'b0, ADR_MUL_H, 16'h0000);
        acc(1'b0, ADR_ACC_E, 16'hFFFF);
        acc(1'b0, ADR_FLAGS, 16'h0AFF);
        @(posedge clock) {start, instr} <= {1'b1, 16'h0001, 8'h00};
        @(posedge clock) start <= 1'b0;
        #1 chk(16'({busy, bad_op}), 16'h0001);
        results();
    end
endmodule
